// ### hdl/pos_top.sv
// power-on operating state selector with apb register access
// assumes: i_nv_state is held by retained storage and stable from power-up; event pins are asynchronous
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`include "pos_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module pos_top
   import pos_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   input  wire logic        i_evt_run,
   input  wire logic        i_evt_manual,
   input  wire logic [1:0]  i_nv_state,
   output logic [1:0]       o_nv_wr_data,
   output logic             o_nv_wr_en,
   output logic [1:0]       o_op_state,
   output logic             o_ctrl_run,
   output logic             o_manual
);

   ////////////////////////////////////////////////////////////////////////////////
   // event pin synchronisers

   logic evt_run_s;
   logic evt_man_s;
   logic evt_run_prev_ff;
   logic evt_man_prev_ff;

   pos_sync u_sync_run
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_evt_run),
      .o_sync    (evt_run_s)
   );

   pos_sync u_sync_man
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_evt_manual),
      .o_sync    (evt_man_s)
   );

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         evt_run_prev_ff <= 1'b0;
         evt_man_prev_ff <= 1'b0;
      end
      else
      begin
         evt_run_prev_ff <= evt_run_s;
         evt_man_prev_ff <= evt_man_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, pready from a flop

   pos_cfg_s                    cfg_ff;
   logic [`POS_MASK_WIDTH-1:0]  mask_ff;
   pos_seq_e                    seq_ff;
   logic [1:0]                  op_ff;
   logic [1:0]                  nv_cache_ff;
   logic                        access;
   logic                        wr_fire;
   logic                        srst_cmd;
   logic                        init_cmd;
   logic                        opreq_cmd;
   logic                        addr_ok;
   logic [31:0]                 rd_mux;

   assign access    = i_psel && i_penable;
   // the write lands on the edge where the master sees pready high
   assign wr_fire   = access && o_pready && i_pwrite && addr_ok;
   assign srst_cmd  = wr_fire && (i_paddr == `POS_OFS_CMD) && i_pwdata[`POS_CMD_SRST_BIT];
   assign init_cmd  = wr_fire && (i_paddr == `POS_OFS_CMD) && i_pwdata[`POS_CMD_INIT_BIT];
   assign opreq_cmd = wr_fire && (i_paddr == `POS_OFS_OPREQ) && (seq_ff == POS_ST_OPER)
                      && (i_pwdata[1:0] != 2'h3);

   always_comb
   begin
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      case (i_paddr)
         `POS_OFS_CFG:    rd_mux = {28'h0000000, cfg_ff.automan_en, cfg_ff.runstop_en, cfg_ff.sel};
         `POS_OFS_MASK:   rd_mux = {24'h000000, mask_ff};
         `POS_OFS_CMD:    rd_mux = 32'h0000_0000;
         `POS_OFS_STATUS: rd_mux = {29'h0000000, (seq_ff != POS_ST_OPER), op_ff};
         `POS_OFS_OPREQ:  rd_mux = {30'h0000000, op_ff};
         default:         addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else if (access && !o_pready)
      begin
         o_pready  <= 1'b1;
         o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
         o_pslverr <= !addr_ok;
      end
      else
      begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // settings

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         cfg_ff.sel        <= `POS_SEL_RESUME;
         cfg_ff.runstop_en <= 1'b0;
         cfg_ff.automan_en <= 1'b0;
      end
      else if (init_cmd)
      begin
         cfg_ff.sel        <= `POS_SEL_RESUME;
         cfg_ff.runstop_en <= 1'b0;
         cfg_ff.automan_en <= 1'b0;
      end
      else if (wr_fire && (i_paddr == `POS_OFS_CFG))
      begin
         // code 3 is not a choice; keep the old selection
         if (i_pwdata[`POS_CFG_SEL_HI:`POS_CFG_SEL_LO] != 2'h3)
         begin
            cfg_ff.sel <= i_pwdata[`POS_CFG_SEL_HI:`POS_CFG_SEL_LO];
         end
         cfg_ff.runstop_en <= i_pwdata[`POS_CFG_RS_BIT];
         cfg_ff.automan_en <= i_pwdata[`POS_CFG_AM_BIT];
      end
   end

   // mask has no init path at all, so parameter init cannot touch it
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         mask_ff <= `POS_MASK_RESET;
      end
      else if (wr_fire && (i_paddr == `POS_OFS_MASK))
      begin
         mask_ff <= i_pwdata[`POS_MASK_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start-up sequence

   pos_seq_e nxt_seq;

   always_comb
   begin
      nxt_seq = seq_ff;
      case (seq_ff)
         POS_ST_RESET: nxt_seq = POS_ST_LOAD;
         POS_ST_LOAD:  nxt_seq = POS_ST_APPLY;
         POS_ST_APPLY: nxt_seq = POS_ST_OPER;
         POS_ST_OPER:  nxt_seq = srst_cmd ? POS_ST_LOAD : POS_ST_OPER;
         default:      nxt_seq = POS_ST_RESET;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         seq_ff <= POS_ST_RESET;
      end
      else
      begin
         seq_ff <= nxt_seq;
      end
   end

   // retained value is caught after reset release, never under reset
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         nv_cache_ff <= `POS_OP_STOP;
      end
      else if (seq_ff == POS_ST_LOAD)
      begin
         // an unknown code in storage falls back to the safe stopped state
         nv_cache_ff <= (i_nv_state == 2'h3) ? `POS_OP_STOP : i_nv_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operating state

   logic [1:0] base_op;
   logic [1:0] nxt_op;

   always_comb
   begin
      case (cfg_ff.sel)
         `POS_SEL_STOP:   base_op = `POS_OP_STOP;
         `POS_SEL_MANUAL: base_op = `POS_OP_MANUAL;
         default:         base_op = nv_cache_ff;
      endcase
   end

   always_comb
   begin
      nxt_op = op_ff;
      if (seq_ff == POS_ST_APPLY)
      begin
         nxt_op = base_op;
         if (cfg_ff.automan_en)
         begin
            if (evt_man_s)
            begin
               nxt_op = `POS_OP_MANUAL;
            end
            else if (base_op == `POS_OP_MANUAL)
            begin
               nxt_op = `POS_OP_STOP;
            end
         end
         if (cfg_ff.runstop_en && (nxt_op != `POS_OP_MANUAL) && (cfg_ff.sel != `POS_SEL_STOP))
         begin
            nxt_op = evt_run_s ? `POS_OP_RUN : `POS_OP_STOP;
         end
      end
      else if (seq_ff == POS_ST_OPER)
      begin
         // in operation only event edges and op requests act, so a level cannot undo the start-up choice
         if (cfg_ff.automan_en && (evt_man_s != evt_man_prev_ff))
         begin
            nxt_op = evt_man_s ? `POS_OP_MANUAL : `POS_OP_STOP;
         end
         else if (cfg_ff.runstop_en && (evt_run_s != evt_run_prev_ff) && (op_ff != `POS_OP_MANUAL))
         begin
            nxt_op = evt_run_s ? `POS_OP_RUN : `POS_OP_STOP;
         end
         else if (opreq_cmd)
         begin
            nxt_op = i_pwdata[1:0];
         end
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         op_ff <= `POS_OP_STOP;
      end
      else
      begin
         op_ff <= nxt_op;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_op_state <= `POS_OP_STOP;
         o_ctrl_run <= 1'b0;
         o_manual   <= 1'b0;
      end
      else
      begin
         o_op_state <= nxt_op;
         o_ctrl_run <= (nxt_op == `POS_OP_RUN);
         o_manual   <= (nxt_op == `POS_OP_MANUAL);
      end
   end

   // write back only in operation, so the value read at start-up is never clobbered
   pos_nv_wr_s nv_wr_ff;

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         nv_wr_ff.data <= `POS_OP_STOP;
         nv_wr_ff.en   <= 1'b0;
      end
      else
      begin
         nv_wr_ff.data <= nxt_op;
         nv_wr_ff.en   <= (seq_ff == POS_ST_OPER) && (nxt_op != op_ff);
      end
   end

   assign o_nv_wr_data = nv_wr_ff.data;
   assign o_nv_wr_en   = nv_wr_ff.en;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   logic apply_plain;
   assign apply_plain = (seq_ff == POS_ST_APPLY) && !cfg_ff.runstop_en && !cfg_ff.automan_en
                        && (cfg_ff.sel == `POS_SEL_RESUME);

   sequence soft_reset_s;
      (seq_ff == POS_ST_OPER) && srst_cmd;
   endsequence

   sequence restart_s;
      (seq_ff == POS_ST_LOAD) ##1 (seq_ff == POS_ST_APPLY) ##1 (seq_ff == POS_ST_OPER);
   endsequence

   soft_restart_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      soft_reset_s |=> restart_s)
      else $error("soft reset did not rerun start-up");

   power_up_a: assert property (@(posedge i_clock)
      i_sys_rst ##1 !i_sys_rst |=> (seq_ff == POS_ST_LOAD) ##1 (seq_ff == POS_ST_APPLY))
      else $error("start-up sequence not entered after reset");

   init_default_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      init_cmd |=> (cfg_ff.sel == `POS_SEL_RESUME) && !cfg_ff.runstop_en && !cfg_ff.automan_en)
      else $error("parameter init did not restore defaults");

   mask_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      init_cmd |=> $stable(mask_ff))
      else $error("parameter init changed the mask");

   resume_run_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      apply_plain && (nv_cache_ff == `POS_OP_RUN) |=> o_ctrl_run && (op_ff == `POS_OP_RUN))
      else $error("resume did not restart running control");

   resume_stop_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      apply_plain && (nv_cache_ff == `POS_OP_STOP) |=> !o_ctrl_run && (op_ff == `POS_OP_STOP))
      else $error("resume did not keep control halted");

   resume_manual_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      apply_plain && (nv_cache_ff == `POS_OP_MANUAL) |=> o_manual)
      else $error("resume did not re-enter manual mode");

   resume_restore_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (seq_ff == POS_ST_LOAD) && (i_nv_state != 2'h3) ##1 apply_plain |=> (op_ff == $past(i_nv_state, 2)))
      else $error("resume did not restore retained state");

   force_stop_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (seq_ff == POS_ST_APPLY) && (cfg_ff.sel == `POS_SEL_STOP) && !(cfg_ff.automan_en && evt_man_s)
      |=> (op_ff == `POS_OP_STOP) && !o_ctrl_run)
      else $error("force stop not applied at power-up");

   man_event_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (seq_ff == POS_ST_APPLY) && cfg_ff.automan_en && (cfg_ff.sel == `POS_SEL_MANUAL)
      |=> o_manual == $past(evt_man_s))
      else $error("auto/manual event level did not win");

   nv_save_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (seq_ff == POS_ST_OPER) && (nxt_op != op_ff) |=> o_nv_wr_en && (o_nv_wr_data == op_ff))
      else $error("state change not written to retained storage");

endmodule

// ### hdl/pos_defines.svh
// register offsets, field positions, reset values and command bits of the power-on state selector
// assumes: included by its bare name from the package and from every design file that needs it
`ifndef POS_DEFINES_SVH
`define POS_DEFINES_SVH

`define POS_OFS_CFG      12'h000
`define POS_OFS_MASK     12'h004
`define POS_OFS_CMD      12'h008
`define POS_OFS_STATUS   12'h00C
`define POS_OFS_OPREQ    12'h010

`define POS_CFG_SEL_LO   0
`define POS_CFG_SEL_HI   1
`define POS_CFG_RS_BIT   2
`define POS_CFG_AM_BIT   3
`define POS_CMD_SRST_BIT 0
`define POS_CMD_INIT_BIT 1
`define POS_STAT_BUSY    2

`define POS_SEL_RESUME   2'h0
`define POS_SEL_STOP     2'h1
`define POS_SEL_MANUAL   2'h2

`define POS_OP_STOP      2'h0
`define POS_OP_RUN       2'h1
`define POS_OP_MANUAL    2'h2

`define POS_MASK_WIDTH   8
`define POS_MASK_RESET   8'hFF

`endif

// ### hdl/pos_pkg.sv
// types shared by the power-on state selector
// assumes: pos_defines.svh sits on the include path
package pos_pkg;
`include "pos_defines.svh"

   typedef enum logic [1:0] {
      POS_ST_RESET,
      POS_ST_LOAD,
      POS_ST_APPLY,
      POS_ST_OPER
   } pos_seq_e;

   typedef struct packed {
      logic [1:0] sel;
      logic       runstop_en;
      logic       automan_en;
   } pos_cfg_s;

   typedef struct packed {
      logic [1:0] data;
      logic       en;
   } pos_nv_wr_s;

endpackage

// ### hdl/pos_sync.sv
// two-stage synchroniser for one asynchronous level
// assumes: i_async comes from a pin outside the i_clock domain
`timescale 1ns/1ns
module pos_sync
   import pos_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_ff;

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         meta_ff <= 1'b0;
         o_sync  <= 1'b0;
      end
      else
      begin
         meta_ff <= i_async;
         o_sync  <= meta_ff;
      end
   end

endmodule

// ### sim/testbench.sv
// self-checking bench for the power-on operating state selector
// assumes: pos_top and pos_pkg compiled first, pos_defines.svh on the include path
`timescale 1ns/1ns
`include "pos_defines.svh"
module testbench;
   import pos_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        evt_run = 1'b0;
   logic        evt_man = 1'b0;
   logic [1:0]  nv = 2'h0;
   logic [1:0]  nv_wr_data;
   logic        nv_wr_en;
   logic [1:0]  op_state;
   logic        ctrl_run;
   logic        manual;
   logic [1:0]  nv_seen;
   logic        nv_hit = 1'b0;
   logic [31:0] rdv;
   logic        err;
   int          n_mismatch = 0;
   int          n_checks = 0;

   pos_top u_pos_top (.i_clock(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_evt_run(evt_run), .i_evt_manual(evt_man),
      .i_nv_state(nv), .o_nv_wr_data(nv_wr_data), .o_nv_wr_en(nv_wr_en),
      .o_op_state(op_state), .o_ctrl_run(ctrl_run), .o_manual(manual));

   initial
   begin
      forever #20 clk = ~clk;
   end

   // sticky capture: the store pulse is one cycle wide and may land inside a bus task
   always @(posedge clk)
   begin
      if (nv_wr_en === 1'b1)
      begin
         nv_hit  <= 1'b1;
         nv_seen <= nv_wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      // one wait state: pready seen on the second access-phase edge
      chk("apb wait", 2, n);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_state(input string name, input logic [1:0] e);
      chk({name, " op"}, e, op_state);
      chk({name, " run"}, e == `POS_OP_RUN, ctrl_run);
      chk({name, " man"}, e == `POS_OP_MANUAL, manual);
      apb(0, `POS_OFS_STATUS, 0);
      chk({name, " status"}, e, rdv[1:0]);
   endtask

   // hardware power-up: reset held, released, outputs valid from the 3rd edge
   task automatic power_up(input logic [1:0] s);
      nv  <= s;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic soft_reset();
      int n;
      n = 0;
      apb(1, `POS_OFS_CMD, 32'h1 << `POS_CMD_SRST_BIT);
      do
      begin
         apb(0, `POS_OFS_STATUS, 0);
         n++;
      end
      while (rdv[`POS_STAT_BUSY] !== 1'b0 && n < 20);
      chk("busy", 0, rdv[`POS_STAT_BUSY]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_resume();
      for (int s = 0; s < 3; s++)
      begin
         power_up(s[1:0]);
         apb(0, `POS_OFS_CFG, 0);
         chk("cfg default", `POS_SEL_RESUME, rdv[1:0]);
         chk_state("resume", s[1:0]);
      end
      $display("test resume done");
   endtask

   task automatic t_force_stop();
      power_up(`POS_OP_RUN);
      evt_run <= 1'b1;
      apb(1, `POS_OFS_CFG, `POS_SEL_STOP | (1 << `POS_CFG_RS_BIT));
      soft_reset();
      chk_state("force stop", `POS_OP_STOP);
      apb(1, `POS_OFS_CFG, `POS_SEL_RESUME | (1 << `POS_CFG_RS_BIT));
      evt_run <= 1'b0;
      soft_reset();
      chk_state("resume evt", `POS_OP_STOP);
      $display("test force stop done");
   endtask

   task automatic t_force_manual();
      power_up(`POS_OP_STOP);
      apb(1, `POS_OFS_CFG, `POS_SEL_MANUAL);
      soft_reset();
      chk_state("force man", `POS_OP_MANUAL);
      apb(1, `POS_OFS_CFG, `POS_SEL_MANUAL | (1 << `POS_CFG_AM_BIT));
      soft_reset();
      chk_state("evt auto", `POS_OP_STOP);
      evt_man <= 1'b1;
      soft_reset();
      chk_state("evt man", `POS_OP_MANUAL);
      evt_man <= 1'b0;
      $display("test force manual done");
   endtask

   task automatic t_store();
      power_up(`POS_OP_STOP);
      nv_hit <= 1'b0;
      apb(1, `POS_OFS_OPREQ, `POS_OP_RUN);
      repeat (4) @(posedge clk);
      chk("nv stored", 1, nv_hit);
      chk("nv data", `POS_OP_RUN, nv_seen);
      chk_state("opreq", `POS_OP_RUN);
      apb(1, `POS_OFS_OPREQ, 32'h3);
      chk_state("opreq code 3", `POS_OP_RUN);
      $display("test store done");
   endtask

   task automatic t_init();
      power_up(`POS_OP_STOP);
      apb(0, `POS_OFS_MASK, 0);
      chk("mask reset", `POS_MASK_RESET, rdv);
      apb(1, `POS_OFS_MASK, 32'h5A);
      apb(1, `POS_OFS_CFG, 32'hD);
      apb(1, `POS_OFS_CMD, 32'h1 << `POS_CMD_INIT_BIT);
      apb(0, `POS_OFS_CFG, 0);
      chk("cfg init", 32'h0, rdv);
      apb(0, `POS_OFS_MASK, 0);
      chk("mask kept", 32'h5A, rdv);
      apb(1, `POS_OFS_CFG, 32'h3);
      apb(0, `POS_OFS_CFG, 0);
      chk("cfg code 3", 32'h0, rdv);
      apb(0, 12'h040, 0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rdv);
      $display("test init done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // whole run is well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      $display("timeout");
      end_of_test();
   end

   initial
   begin
      t_resume();
      t_force_stop();
      t_force_manual();
      t_store();
      t_init();
      end_of_test();
   end
endmodule
